// ===== rtl/pmsm_pkg.sv
package pmsm_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [3:0] PMSM_ADDR_CTRL = 4'h0;
  localparam logic [3:0] PMSM_ADDR_SHUTDOWN = 4'h1;
  localparam logic [3:0] PMSM_ADDR_FAULT_LOG = 4'h2;
  localparam logic [3:0] PMSM_ADDR_STATUS = 4'h3;
  localparam logic [3:0] PMSM_ADDR_RETRY = 4'h4;
  localparam logic [3:0] PMSM_ADDR_TIMING = 4'h5;
  localparam logic [3:0] PMSM_ADDR_SCRATCH = 4'h6;

  // ctrl bit positions
  localparam int PMSM_C_BASE_EN = 0;
  localparam int PMSM_C_FULL_PWR = 1;
  localparam int PMSM_C_BKP_PD = 2;
  localparam int PMSM_C_BKP_SD = 3;
  localparam int PMSM_C_BKP_EN = 4;
  localparam int PMSM_C_INT_FAST = 5;
  localparam int PMSM_C_HOST_FAST = 6;
  localparam int PMSM_C_KEY_FAST = 7;
  localparam int PMSM_C_LOCK_EN = 8;
  localparam int PMSM_C_WD_EN = 9;
  localparam int PMSM_C_WD_USE = 10;
  localparam int PMSM_C_RTC_REQ = 11;
  localparam int PMSM_C_WD_KICK = 12;
  localparam logic [15:0] PMSM_CTRL_RESET = 16'h0000;

  // fault log bits
  localparam int PMSM_F_KEY = 0;
  localparam int PMSM_F_REQ = 1;
  localparam int PMSM_F_WDOG = 2;
  localparam int PMSM_F_UV = 3;
  localparam int PMSM_F_TEMP = 4;
  localparam int PMSM_F_SHUT = 5;

  localparam logic [3:0] PMSM_RETRY_RESET = 4'h3;
  localparam logic [7:0] PMSM_DWELL_RESET = 8'h04;
  localparam logic [7:0] PMSM_LONGPRESS_RESET = 8'h08;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PMSM_CLK_MHZ = 100;
  localparam int PMSM_HOLD_MS = 1000;
  localparam int PMSM_HOLD_CYCLES = PMSM_HOLD_MS * 1000 * PMSM_CLK_MHZ;
  localparam int PMSM_WD_MS = 2000;
  localparam int PMSM_WD_CYCLES = PMSM_WD_MS * 1000 * PMSM_CLK_MHZ;
  localparam int PMSM_UNIT_US = 1000;
  localparam int PMSM_UNIT_CYCLES = PMSM_UNIT_US * PMSM_CLK_MHZ;
  localparam int PMSM_STEP_US = 128;
  localparam int PMSM_STEP_CYCLES = PMSM_STEP_US * PMSM_CLK_MHZ;
  localparam logic [4:0] PMSM_SEQ_TOP = 5'h0F;
  localparam logic [4:0] PMSM_SEQ_SYS_END = 5'h07;

  typedef enum logic [2:0] {
    PMSM_NO_POWER, PMSM_RTC, PMSM_RESET, PMSM_POWERDOWN, PMSM_SYSTEM, PMSM_ACTIVE
  } pmsm_mode_t;
endpackage

// ===== rtl/pmsm_ctrl.sv
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// [R1] no-power moves to reset once system supply is above threshold
// [R2] rtc mode on software request, battery-only supply or supply removal
// [R3] backup-on-powerdown bit sends powerdown straight on to rtc mode
// [R4] rtc exits on supply recovery, power key or alarm; gpio held off
// [R5] with backup enabled, supply fault plus backup-on-shutdown or por-lower enters rtc
// [R6] reset on host-interruptible long key, reset request fall, or shutdown write
// [R7] watchdog miss, undervoltage or overtemperature force reset
// [R8] fast-off bits per fault source skip sequencer delays
// [R9] fault log records key and request causes; write one clears
// [R10] key fast-off turns long key press into full power-on reset
// [R11] shutdown asserts reset output first; held through reset mode
// [R12] entering reset clears pending user and system events
// [R13] leaving reset reloads configuration except listed kept registers
// [R14] self-clearing causes; held reset request blocks reset exit to powerdown, not to rtc
// [R15] minimum reset dwell only on shutdown path, not cold boot
// [R16] long key sets flag and irq; shutdown after 1 s unless cleared
// [R17] active powers down on base enable low; key release only drops active to system, which steps back up to active
// [R18] retry counter drops per watchdog timeout; zero freezes powerdown
// [R19] frozen stays; wakeup or base enable picks active or system
// [R20] retry reload and unfreeze on wakeup release, reset or rtc entry
// [R21] shutdown continues from powerdown to reset automatically
// [R22] active only after power-up done and watchdog enabled if used
// [R23] asynchronous trigger inputs are synchronised first
module pmsm_ctrl
  import pmsm_pkg::*;
#(
  parameter int HOLD_CYCLES = PMSM_HOLD_CYCLES,
  parameter int WD_CYCLES = PMSM_WD_CYCLES,
  parameter int UNIT_CYCLES = PMSM_UNIT_CYCLES,
  parameter int STEP_CYCLES = PMSM_STEP_CYCLES
) (
  input wire logic clk_in, // 100 MHz clock
  input wire logic reset_n_in, // sync reset, active low
  input wire logic [3:0] addr_in, // register address
  input wire logic [15:0] wdata_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [15:0] rdata_out, // read data, cycle after strobe
  input wire logic supply_ok_in, // system supply above threshold
  input wire logic battery_only_in, // backup battery sole supply
  input wire logic supply_fault_in, // supply fault (start-supply)
  input wire logic below_por_lower_in, // below por_lower_threshold
  input wire logic undervolt_in, // below lower fault threshold
  input wire logic overtemp_in, // junction over-temperature
  input wire logic rtc_alarm_in, // rtc alarm
  input wire logic power_key_n_in, // power key, active low
  input wire logic reset_request_n_in, // reset request pin, active low
  input wire logic base_enable_pin_in, // base domain enable pin
  input wire logic full_power_pin_in, // full power enable pin
  input wire logic level_wakeup_in, // level-sensitive wakeup
  output logic reset_out_n_out, // system reset, active low
  output logic irq_out_n_out, // interrupt, active low
  output logic gpio_enable_out, // gpios operational
  output logic por_out, // full device power-on reset pulse
  output logic otp_reload_out, // configuration reload pulse
  output logic keep_autoboot_out, // reload keeps auto power-on
  output logic events_clear_out, // clear pending events pulse
  output logic [2:0] mode_out // current power mode
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [4:0] sync1_reg, sync2_reg, prev_reg;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sync1_reg <= 5'h03; // idle pin levels, no false edge after reset
      sync2_reg <= 5'h03;
      prev_reg <= 5'h03;
    end else begin
      sync1_reg <= {level_wakeup_in, full_power_pin_in, base_enable_pin_in,
                    reset_request_n_in, power_key_n_in}; // [R23]
      sync2_reg <= sync1_reg; // [R23]
      prev_reg <= sync2_reg;
    end
  end
  wire key_down = !sync2_reg[0];
  wire key_press = prev_reg[0] && !sync2_reg[0];
  wire key_release = !prev_reg[0] && sync2_reg[0];
  wire req_held = !sync2_reg[1];
  wire req_fall = prev_reg[1] && !sync2_reg[1];

  // ****************************************************************
  // registers
  // ****************************************************************
  pmsm_mode_t mode_reg;
  logic [15:0] ctrl_reg;
  logic [5:0] fault_reg;
  logic [3:0] retry_reg, retry_cnt_reg;
  logic [7:0] dwell_reg, longpress_reg;
  logic [15:0] scratch_reg;
  logic shut_wr, fault_wr;
  assign shut_wr = wr_in && addr_in == PMSM_ADDR_SHUTDOWN;
  assign fault_wr = wr_in && addr_in == PMSM_ADDR_FAULT_LOG;
  wire base_en = ctrl_reg[PMSM_C_BASE_EN] || sync2_reg[2];
  wire full_pwr = ctrl_reg[PMSM_C_FULL_PWR] || sync2_reg[3];
  wire wake = sync2_reg[4];
  wire frozen = ctrl_reg[PMSM_C_LOCK_EN] && retry_cnt_reg == 4'h0;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= PMSM_CTRL_RESET;
      retry_reg <= PMSM_RETRY_RESET;
      dwell_reg <= PMSM_DWELL_RESET;
      longpress_reg <= PMSM_LONGPRESS_RESET;
    end else if (otp_reload_out) begin
      ctrl_reg <= PMSM_CTRL_RESET; // [R13]
      retry_reg <= PMSM_RETRY_RESET;
      dwell_reg <= PMSM_DWELL_RESET;
      longpress_reg <= PMSM_LONGPRESS_RESET;
    end else if (wr_in) begin
      if (addr_in == PMSM_ADDR_CTRL) begin
        ctrl_reg <= wdata_in;
      end else if (addr_in == PMSM_ADDR_RETRY) begin
        retry_reg <= wdata_in[3:0];
      end else if (addr_in == PMSM_ADDR_TIMING) begin
        dwell_reg <= wdata_in[7:0];
        longpress_reg <= wdata_in[15:8];
      end
    end else begin
      ctrl_reg[PMSM_C_RTC_REQ] <= 1'b0;
      ctrl_reg[PMSM_C_WD_KICK] <= 1'b0;
    end
  end

  // scratch survives reset mode
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      scratch_reg <= 16'h0000;
    end else if (wr_in && addr_in == PMSM_ADDR_SCRATCH) begin
      scratch_reg <= wdata_in; // [R13]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      rdata_out <= 16'h0000;
    end else if (rd_in) begin
      case (addr_in)
        PMSM_ADDR_CTRL: rdata_out <= ctrl_reg;
        PMSM_ADDR_FAULT_LOG: rdata_out <= {10'h000, fault_reg};
        PMSM_ADDR_STATUS: rdata_out <= {8'h00, retry_cnt_reg, frozen, mode_reg};
        PMSM_ADDR_RETRY: rdata_out <= {12'h000, retry_reg};
        PMSM_ADDR_TIMING: rdata_out <= {longpress_reg, dwell_reg};
        PMSM_ADDR_SCRATCH: rdata_out <= scratch_reg;
        default: rdata_out <= 16'h0000;
      endcase
    end else begin
      rdata_out <= 16'h0000;
    end
  end

  // ****************************************************************
  // key timing, watchdog, ms tick
  // ****************************************************************
  logic [31:0] unit_reg, wd_reg, hold_reg;
  logic [7:0] press_ms_reg;
  logic long_seen_reg, hold_reg_on;
  wire tick = unit_reg == 32'(UNIT_CYCLES - 1);
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || tick || events_clear_out) begin // [R15]
      unit_reg <= 32'h0000_0000;
    end else begin
      unit_reg <= unit_reg + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !key_down) begin
      press_ms_reg <= 8'h00;
    end else if (tick && press_ms_reg != 8'hFF) begin
      press_ms_reg <= press_ms_reg + 8'h01;
    end
  end
  wire long_press = key_down && !long_seen_reg && press_ms_reg >= longpress_reg; // [R6]
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !key_down) begin
      long_seen_reg <= 1'b0;
    end else if (long_press) begin
      long_seen_reg <= 1'b1;
    end
  end
  wire wd_on = ctrl_reg[PMSM_C_WD_EN] && mode_reg == PMSM_ACTIVE;
  wire wd_timeout = wd_on && wd_reg == 32'(WD_CYCLES - 1); // [R7]
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !wd_on || ctrl_reg[PMSM_C_WD_KICK] || wd_timeout) begin
      wd_reg <= 32'h0000_0000;
    end else begin
      wd_reg <= wd_reg + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // fault log and long-press hold window
  // ****************************************************************
  wire fault_trip = wd_timeout || undervolt_in || overtemp_in;
  wire hold_done = hold_reg_on && hold_reg == 32'(HOLD_CYCLES - 1);
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fault_reg <= 6'h00;
    end else begin
      fault_reg <= (fault_wr ? fault_reg & ~wdata_in[5:0] : fault_reg) // [R9]
        | {shut_wr, overtemp_in, undervolt_in, wd_timeout, req_fall, long_press}; // [R9]
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !fault_reg[PMSM_F_KEY] || hold_done) begin
      hold_reg_on <= long_press && mode_reg != PMSM_RESET; // [R16]
      hold_reg <= 32'h0000_0000;
    end else begin
      hold_reg_on <= 1'b1;
      hold_reg <= hold_reg + 32'h0000_0001; // [R16]
    end
  end
  assign irq_out_n_out = !hold_reg_on; // [R16]

  // ****************************************************************
  // mode machine
  // ****************************************************************
  logic shutdown_reg, fast_reg, cold_reg;
  logic [4:0] seq_reg;
  logic [31:0] step_reg;
  logic [7:0] dwell_ms_reg;
  wire step_tick = fast_reg || step_reg == 32'(STEP_CYCLES - 1); // [R8]
  wire rtc_entry = ctrl_reg[PMSM_C_RTC_REQ] || battery_only_in || !supply_ok_in // [R2]
    || (ctrl_reg[PMSM_C_BKP_EN] && ((supply_fault_in && ctrl_reg[PMSM_C_BKP_SD]) // [R5]
    || below_por_lower_in));
  wire key_reset = hold_done && fault_reg[PMSM_F_KEY]; // [R16]
  wire host_reset = req_fall || shut_wr; // [R6]
  wire up_mode = mode_reg == PMSM_SYSTEM || mode_reg == PMSM_ACTIVE || mode_reg == PMSM_POWERDOWN;
  wire start_shut = up_mode && !shutdown_reg && (key_reset || host_reset || fault_trip);
  wire sel_fast = fault_trip ? ctrl_reg[PMSM_C_INT_FAST] : host_reset ? ctrl_reg[PMSM_C_HOST_FAST]
    : ctrl_reg[PMSM_C_KEY_FAST]; // [R8]
  wire want_up = wake || base_en; // [R19]
  wire up_ok = !ctrl_reg[PMSM_C_WD_USE] || ctrl_reg[PMSM_C_WD_EN];

  always_ff @(posedge clk_in) begin
    if (!reset_n_in || step_tick || mode_reg == PMSM_RESET) begin
      step_reg <= 32'h0000_0000;
    end else begin
      step_reg <= step_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mode_reg <= PMSM_NO_POWER;
      shutdown_reg <= 1'b0;
      fast_reg <= 1'b0;
      cold_reg <= 1'b1;
      seq_reg <= 5'h00;
      dwell_ms_reg <= 8'h00;
      reset_out_n_out <= 1'b0;
      por_out <= 1'b0;
      otp_reload_out <= 1'b0;
      events_clear_out <= 1'b0;
    end else begin
      por_out <= 1'b0;
      otp_reload_out <= 1'b0;
      events_clear_out <= 1'b0;
      if (start_shut && key_reset && ctrl_reg[PMSM_C_KEY_FAST]) begin
        por_out <= 1'b1; // [R10]
        mode_reg <= PMSM_NO_POWER;
        reset_out_n_out <= 1'b0;
      end else if (start_shut) begin
        shutdown_reg <= 1'b1;
        fast_reg <= sel_fast; // [R8]
        reset_out_n_out <= 1'b0; // [R11]
        cold_reg <= 1'b0; // [R15]
        if (mode_reg != PMSM_POWERDOWN) begin
          mode_reg <= PMSM_SYSTEM;
        end
      end else begin
        case (mode_reg)
          PMSM_NO_POWER: begin
            if (supply_ok_in) begin
              mode_reg <= PMSM_RESET; // [R1]
              events_clear_out <= 1'b1;
              cold_reg <= 1'b1;
              dwell_ms_reg <= 8'h00;
            end
          end
          PMSM_RTC: begin
            if ((supply_ok_in && !battery_only_in) || key_press || rtc_alarm_in) begin
              mode_reg <= PMSM_RESET; // [R4]
              events_clear_out <= 1'b1; // [R12]
              reset_out_n_out <= 1'b0; // [R11]
              cold_reg <= 1'b1;
              dwell_ms_reg <= 8'h00;
            end
          end
          PMSM_RESET: begin
            reset_out_n_out <= 1'b0; // [R11]
            if (tick && dwell_ms_reg != 8'hFF) begin
              dwell_ms_reg <= dwell_ms_reg + 8'h01;
            end
            if (rtc_entry) begin
              mode_reg <= PMSM_RTC;
              otp_reload_out <= 1'b1; // [R13]
            end else if (!req_held && (cold_reg || dwell_ms_reg >= dwell_reg)) begin // [R14] [R15]
              mode_reg <= PMSM_POWERDOWN;
              otp_reload_out <= 1'b1; // [R13]
              shutdown_reg <= 1'b0;
              fast_reg <= 1'b0;
              seq_reg <= 5'h00;
            end
          end
          PMSM_POWERDOWN: begin
            if (shutdown_reg || rtc_entry) begin
              mode_reg <= rtc_entry ? PMSM_RTC : PMSM_RESET; // [R21] [R2]
              events_clear_out <= !rtc_entry; // [R12]
              dwell_ms_reg <= 8'h00;
              reset_out_n_out <= 1'b0;
            end else if (ctrl_reg[PMSM_C_BKP_PD]) begin
              mode_reg <= PMSM_RTC; // [R3]
            end else if (!frozen && want_up) begin // [R19]
              mode_reg <= PMSM_SYSTEM;
              reset_out_n_out <= 1'b1;
            end
          end
          PMSM_SYSTEM, PMSM_ACTIVE: begin
            if (rtc_entry) begin
              mode_reg <= PMSM_RTC; // [R2]
            end else if (shutdown_reg || !want_up || (mode_reg == PMSM_ACTIVE && key_release)) begin // [R17]
              if (step_tick) begin
                if (seq_reg == 5'h00) begin
                  mode_reg <= PMSM_POWERDOWN; // [R21]
                end else begin
                  seq_reg <= seq_reg - 5'h01;
                end
              end
              if (mode_reg == PMSM_ACTIVE) begin
                mode_reg <= PMSM_SYSTEM;
              end
            end else if (step_tick) begin
              if (seq_reg < (full_pwr ? PMSM_SEQ_TOP : PMSM_SEQ_SYS_END)) begin
                seq_reg <= seq_reg + 5'h01;
              end else if (full_pwr && up_ok) begin
                mode_reg <= PMSM_ACTIVE; // [R22] [R19]
              end else if (!full_pwr && seq_reg > PMSM_SEQ_SYS_END) begin
                seq_reg <= seq_reg - 5'h01;
              end
              if (mode_reg == PMSM_ACTIVE && !full_pwr) begin
                mode_reg <= PMSM_SYSTEM;
              end
            end
          end
          default: mode_reg <= PMSM_NO_POWER;
        endcase
      end
    end
  end

  // ****************************************************************
  // retry counter and freeze
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || mode_reg == PMSM_RESET || mode_reg == PMSM_RTC) begin
      retry_cnt_reg <= reset_n_in ? retry_reg : PMSM_RETRY_RESET; // [R20]
    end else if (frozen && !want_up) begin
      retry_cnt_reg <= retry_reg; // [R20]
    end else if (wd_timeout && ctrl_reg[PMSM_C_LOCK_EN] && retry_cnt_reg != 4'h0) begin
      retry_cnt_reg <= retry_cnt_reg - 4'h1; // [R18]
    end
  end

  assign gpio_enable_out = mode_reg != PMSM_RTC && mode_reg != PMSM_NO_POWER; // [R4]
  assign keep_autoboot_out = supply_fault_in; // [R13]
  assign mode_out = mode_reg;
endmodule

// ===== bench/pmsm_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// host side: drives the reset request line on command
// ****************************************************************
module pmsm_host_model #(
  parameter int HOLD = 10
) (
  input wire logic clk_in, // clock
  input wire logic start_in, // one-cycle request pulse
  output logic reset_request_n_out // request line, pulled up
);
  int cnt = 0;
  initial reset_request_n_out = 1'b1;
  always @(posedge clk_in) begin
    if (start_in) begin
      cnt <= HOLD;
      reset_request_n_out <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt <= 0;
      reset_request_n_out <= 1'b1; // released to pull-up
    end
  end
endmodule

// ===== bench/pmsm_ctrl_monitor.sv
`timescale 1ns/1ns
module pmsm_ctrl_monitor
  import pmsm_pkg::*;
(
  input wire logic clk_in, // clock
  input wire logic reset_n_in, // sync reset
  input wire logic supply_ok_in, // supply good
  input wire logic battery_only_in, // battery only
  input wire logic overtemp_in, // over-temperature
  input wire logic reset_request_n_in, // reset request
  input wire logic reset_out_n_out, // reset output
  input wire logic gpio_enable_out, // gpio enable
  input wire logic otp_reload_out, // reload pulse
  input wire logic events_clear_out, // event clear pulse
  input wire logic [2:0] mode_out // mode
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  boot_reset_a: assert property ((mode_out == PMSM_NO_POWER && supply_ok_in && !battery_only_in) |->
    ##[1:4] mode_out == PMSM_RESET) else $error("no reset mode after supply rise");
  rtc_entry_a: assert property (($rose(battery_only_in) && mode_out == PMSM_POWERDOWN) |->
    ##[1:4] mode_out == PMSM_RTC) else $error("no rtc mode on battery only");
  gpio_rtc_a: assert property (mode_out == PMSM_RTC |-> !gpio_enable_out)
    else $error("gpio enabled in rtc mode");
  reset_hold_a: assert property (mode_out == PMSM_RESET |-> !reset_out_n_out)
    else $error("reset output released in reset mode");
  temp_reset_a: assert property ((overtemp_in && mode_out == PMSM_ACTIVE) |-> ##[0:3] !reset_out_n_out)
    else $error("overtemperature did not assert reset");
  event_clear_a: assert property ((mode_out == PMSM_RESET && $past(mode_out) != PMSM_RESET) |->
    (events_clear_out || $past(events_clear_out))) else $error("events not cleared on reset entry");
  reload_exit_a: assert property (($past(mode_out) == PMSM_RESET && mode_out != PMSM_RESET) |->
    (otp_reload_out || $past(otp_reload_out))) else $error("no reload on reset exit");
  request_hold_a: assert property ((mode_out == PMSM_RESET && !reset_request_n_in
    && !$past(reset_request_n_in) && !$past(reset_request_n_in, 2)) |=> mode_out == PMSM_RESET)
    else $error("left reset with request held");
endmodule
bind pmsm_ctrl pmsm_ctrl_monitor i_mon (.clk_in(clk_in), .reset_n_in(reset_n_in), .supply_ok_in(supply_ok_in),
  .battery_only_in(battery_only_in), .overtemp_in(overtemp_in), .reset_request_n_in(reset_request_n_in),
  .reset_out_n_out(reset_out_n_out), .gpio_enable_out(gpio_enable_out), .otp_reload_out(otp_reload_out),
  .events_clear_out(events_clear_out), .mode_out(mode_out));

// ===== bench/power_mode_state_machine_test.sv
`timescale 1ns/1ns
module power_mode_state_machine_test;
  import pmsm_pkg::*;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0, rd_in = 1'b0, supply_ok_in = 1'b0, battery_only_in = 1'b0, overtemp_in = 1'b0;
  logic power_key_n_in = 1'b1, base_enable_pin_in = 1'b0, full_power_pin_in = 1'b0, host_go = 1'b0;
  logic undervolt_in = 1'b0, rtc_alarm_in = 1'b0, level_wakeup_in = 1'b0;
  logic [15:0] rdata_out, d;
  logic reset_request_n, reset_out_n_out, irq_out_n_out, gpio_enable_out, por_out, otp_reload_out;
  logic keep_autoboot_out, events_clear_out;
  logic [2:0] mode_out;
  int n_errors = 0, num_checks = 0, n;
  always #5 clk_in = ~clk_in;
  pmsm_ctrl #(.HOLD_CYCLES(200), .WD_CYCLES(400), .UNIT_CYCLES(10), .STEP_CYCLES(20)) i_dut (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .supply_ok_in(supply_ok_in), .battery_only_in(battery_only_in),
    .supply_fault_in(1'b0), .below_por_lower_in(1'b0), .undervolt_in(undervolt_in), .overtemp_in(overtemp_in),
    .rtc_alarm_in(rtc_alarm_in), .power_key_n_in(power_key_n_in), .reset_request_n_in(reset_request_n),
    .base_enable_pin_in(base_enable_pin_in), .full_power_pin_in(full_power_pin_in),
    .level_wakeup_in(level_wakeup_in),
    .reset_out_n_out(reset_out_n_out), .irq_out_n_out(irq_out_n_out), .gpio_enable_out(gpio_enable_out),
    .por_out(por_out), .otp_reload_out(otp_reload_out), .keep_autoboot_out(keep_autoboot_out),
    .events_clear_out(events_clear_out), .mode_out(mode_out));
  pmsm_host_model #(.HOLD(80)) i_host (.clk_in(clk_in), .start_in(host_go), .reset_request_n_out(reset_request_n));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode_out !== m && n < lim) begin
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  task automatic bring_up();
    wait_mode(PMSM_POWERDOWN, 3000);
    wr(PMSM_ADDR_CTRL, 16'h0060); // fast internal and host shutdown
    base_enable_pin_in <= 1'b1;
    full_power_pin_in <= 1'b1;
    wait_mode(PMSM_ACTIVE, 5000);
    check(mode_out, PMSM_ACTIVE);
    check(reset_out_n_out, 1'b1);
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_boot();
    supply_ok_in <= 1'b1;
    wait_mode(PMSM_RESET, 20);
    check(mode_out, PMSM_RESET);
    check(reset_out_n_out, 1'b0);
    wait_mode(PMSM_POWERDOWN, 30);
    check(n < 30, 1'b1); // no dwell at cold boot
    rd(PMSM_ADDR_CTRL);
    check(d, PMSM_CTRL_RESET);
    rd(PMSM_ADDR_TIMING);
    check(d, {PMSM_LONGPRESS_RESET, PMSM_DWELL_RESET});
    rd(PMSM_ADDR_RETRY);
    check(d, {12'h000, PMSM_RETRY_RESET});
    rd(4'hF);
    check(d, 16'h0000);
    $display("test boot done");
  endtask
  task automatic test_request();
    @(posedge clk_in);
    host_go <= 1'b1;
    @(posedge clk_in);
    host_go <= 1'b0;
    wait_mode(PMSM_RESET, 400);
    check(mode_out, PMSM_RESET);
    base_enable_pin_in <= 1'b0;
    full_power_pin_in <= 1'b0;
    wait_mode(PMSM_POWERDOWN, 200);
    check(n >= 40, 1'b1); // dwell of 4 ticks of 10 cycles
    check(n >= 60, 1'b1); // request still held after dwell
    rd(PMSM_ADDR_FAULT_LOG);
    check(d[PMSM_F_REQ], 1'b1);
    wr(PMSM_ADDR_FAULT_LOG, 16'h0002);
    rd(PMSM_ADDR_FAULT_LOG);
    check(d[PMSM_F_REQ], 1'b0);
    $display("test request done");
  endtask
  task automatic test_temp_rtc();
    overtemp_in <= 1'b1;
    wait_mode(PMSM_RESET, 400);
    check(mode_out, PMSM_RESET);
    overtemp_in <= 1'b0;
    base_enable_pin_in <= 1'b0;
    full_power_pin_in <= 1'b0;
    wait_mode(PMSM_POWERDOWN, 200);
    check(mode_out, PMSM_POWERDOWN); // self-clearing cause
    rd(PMSM_ADDR_FAULT_LOG);
    check(d[PMSM_F_TEMP], 1'b1);
    wr(PMSM_ADDR_FAULT_LOG, 16'h0010);
    battery_only_in <= 1'b1;
    wait_mode(PMSM_RTC, 20);
    check(mode_out, PMSM_RTC);
    check(gpio_enable_out, 1'b0);
    battery_only_in <= 1'b0;
    wait_mode(PMSM_RESET, 20);
    check(mode_out !== PMSM_RTC, 1'b1);
    $display("test temp rtc done");
  endtask
  task automatic test_key();
    power_key_n_in <= 1'b0;
    n = 0;
    while (irq_out_n_out !== 1'b0 && n < 300) begin
      @(posedge clk_in);
      #1 n++;
    end
    check(irq_out_n_out, 1'b0);
    rd(PMSM_ADDR_FAULT_LOG);
    check(d, 16'h0001); // only key flag set
    wr(PMSM_ADDR_FAULT_LOG, 16'h0001);
    repeat (250) @(posedge clk_in);
    #1 check(mode_out, PMSM_ACTIVE); // host cleared flag in time
    check(irq_out_n_out, 1'b1);
    $display("test key done");
  endtask
  task automatic test_wake_rtc();
    base_enable_pin_in <= 1'b0;
    full_power_pin_in <= 1'b0;
    wait_mode(PMSM_POWERDOWN, 1000);
    check(mode_out, PMSM_POWERDOWN);
    power_key_n_in <= 1'b1;
    rd(PMSM_ADDR_STATUS);
    check(d, {8'h00, PMSM_RETRY_RESET, 1'b0, PMSM_POWERDOWN});
    undervolt_in <= 1'b1;
    wait_mode(PMSM_RESET, 20);
    check(mode_out, PMSM_RESET);
    undervolt_in <= 1'b0;
    wait_mode(PMSM_POWERDOWN, 200);
    rd(PMSM_ADDR_FAULT_LOG);
    check(d[PMSM_F_UV], 1'b1);
    level_wakeup_in <= 1'b1;
    repeat (300) @(posedge clk_in);
    #1 check(mode_out, PMSM_SYSTEM); // level wakeup without full power
    battery_only_in <= 1'b1;
    wait_mode(PMSM_RTC, 20);
    check(mode_out, PMSM_RTC);
    rtc_alarm_in <= 1'b1;
    wait_mode(PMSM_RESET, 20);
    check(mode_out, PMSM_RESET); // alarm exit
    rtc_alarm_in <= 1'b0;
    level_wakeup_in <= 1'b0;
    wait_mode(PMSM_RTC, 20);
    check(mode_out, PMSM_RTC); // battery still sole supply
    battery_only_in <= 1'b0;
    wait_mode(PMSM_POWERDOWN, 50);
    check(mode_out, PMSM_POWERDOWN);
    $display("test wake rtc done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #400000;
    n_errors++;
    close_out();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'b1;
    test_boot();
    bring_up();
    test_request();
    bring_up();
    test_temp_rtc();
    bring_up();
    test_key();
    test_wake_rtc();
    close_out();
  end
endmodule
